// file: sdp_regs.svh
// Purpose: register offsets, fields, reset values and timing of the packetizer
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef SDP_REGS_SVH
`define SDP_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define SDP_A_CTRL   8'h00
`define SDP_A_START1 8'h04
`define SDP_A_START2 8'h08
`define SDP_A_END1   8'h0c
`define SDP_A_END2   8'h10
`define SDP_A_TRAIL  8'h14
`define SDP_A_LENCFG 8'h18
`define SDP_A_LENADJ 8'h1c
`define SDP_A_GAP    8'h20
`define SDP_A_FIXED  8'h24
`define SDP_A_MTU    8'h28
`define SDP_A_STATUS 8'h2c
`define SDP_A_FRAMES 8'h30

// ****************************************
// fields
// ****************************************
`define SDP_F_CTRL   4:0
`define SDP_F_CNT    9:0
`define SDP_F_LOFF   9:0
`define SDP_F_LSIZE  17:16
`define SDP_F_GAP    15:0
`define SDP_F_LEN    10:0

// ****************************************
// reset values and limits
// ****************************************
`define SDP_MTU_RST   11'h230
`define SDP_MTU_MAX   11'h400
`define SDP_FIXED_RST 11'h230
`define SDP_GAP_MIN   16'h0003
`define SDP_LSIZE_RST 2'h1
`define SDP_LSIZE_MAX 2'h2

// ****************************************
// timing
// ****************************************
`define SDP_CLK_NS 25
`define SDP_MS_NS  1000000
`define SDP_MS_CYC (`SDP_MS_NS / `SDP_CLK_NS)

`endif

// file: sdp_pkg.sv
// Purpose: types shared by the packetizer
// Assumes: nothing
// Notes:   offsets live in sdp_regs.svh
package sdp_pkg;
    typedef enum logic [2:0] {
        SDP_HUNT  = 3'b001,
        SDP_BODY  = 3'b010,
        SDP_TRAIL = 3'b100
    } sdp_state_e;

    typedef struct packed {
        logic [5:0]  rsvd;
        logic [1:0]  size;
        logic [23:0] seq;
    } sdp_pat_s;

    typedef struct packed {
        logic       empty;
        logic       last;
        logic [7:0] data;
    } sdp_word_s;

    typedef struct packed {
        logic netord;
        logic fix;
        logic gap;
        logic len;
        logic pat;
    } sdp_ctrl_s;
endpackage : sdp_pkg

// file: sdp_packetizer.sv
// Purpose: frames serial receive bytes into datagrams for the network side
// Assumes: one clock, APB registers, DEPTH a power of two
// Notes:   patterns are right aligned, last byte of a pattern in bits 7:0
// Behaviour
// - In pattern mode a datagram closes when either tail pattern has arrived.
// - After a tail match the set number of trailer bytes is still collected.
// - With both lead sizes zero the tail alone closes the datagram.
// - In length mode collection is armed by the lead pattern, then the length is read.
// - A lead pattern holds at most three bytes.
// - The length field sits at a set zero-based offset and has a set size.
// - The length counts the whole datagram, corrected by an extra byte count.
// - Network order puts the high byte first, otherwise the low byte first.
// - The datagram closes when its byte count equals length plus extra count.
// - In gap mode the datagram closes when no byte comes within the idle time.
// - The idle time is at least 3 ms and measured to within about a character.
// - In fixed mode the datagram closes after the set number of bytes.
// - The fixed count is limited to the transfer size, 560 by default, 1024 at most.
// - Reaching the transfer size always closes the datagram.
// - Each option acts only while its own enable is set.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sdp_regs.svh"

module sdp_fifo #(
    parameter int W     = 10,
    parameter int DEPTH = 32
) (
    // clock
    input  wire logic         ref_clk_i,
    input  wire logic         rstn_i,
    input  wire logic         ce_i,
    // fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_reg [DEPTH];
    logic [AW:0]  wr_reg;
    logic [AW:0]  wr_next;
    logic [AW:0]  rd_reg;
    logic [AW:0]  rd_next;
    logic         push;
    logic         pop;

    always_comb begin
        in_ready_o  = ce_i && ((wr_reg - rd_reg) != (AW+1)'(DEPTH));
        out_valid_o = ce_i && (wr_reg != rd_reg);
        push        = in_valid_i && in_ready_o;
        pop         = out_valid_o && out_ready_i;
        wr_next     = wr_reg + (AW+1)'(push);
        rd_next     = rd_reg + (AW+1)'(pop);
        out_data_o  = mem_reg[rd_reg[AW-1:0]];
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    // storage needs no reset, pointers guard it
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_reg[wr_reg[AW-1:0]] <= in_data_i;
        end
    end
endmodule : sdp_fifo

module sdp_packetizer #(
    parameter int MS_CYC = `SDP_MS_CYC,
    parameter int DEPTH  = 32
) (
    // clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rstn_i,
    input  wire logic              ce_i,
    // apb slave
    input  wire logic [7:0]        paddr_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [31:0]       pwdata_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // serial receive bytes
    input  wire logic              rx_valid_i,
    input  wire logic [7:0]        rx_data_i,
    output logic                   rx_ready_o,
    // network transmit path
    output logic                   net_valid_o,
    output sdp_pkg::sdp_word_s     net_word_o,
    input  wire logic              net_ready_i
);
    import sdp_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    sdp_ctrl_s   c_reg, c_next;
    sdp_pat_s    st1_reg, st1_next, st2_reg, st2_next;
    sdp_pat_s    en1_reg, en1_next, en2_reg, en2_next;
    logic [9:0]  pextra_reg, pextra_next, loff_reg, loff_next;
    logic [9:0]  lextra_reg, lextra_next;
    logic [1:0]  lsize_reg, lsize_next;
    logic [15:0] gap_reg, gap_next;
    logic [10:0] fixed_reg, fixed_next, mtu_reg, mtu_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        ack_reg, ack_next;
    logic        wr_en, hit;
    logic [10:0] fixed_eff;
    logic [15:0] gap_eff;
    // framer state is declared here because the status read below looks at it
    sdp_state_e  state_reg, state_next;
    logic [23:0] hist_reg, hist_next, hist_in;
    logic [10:0] cnt_reg, cnt_next, pos_reg, pos_next, cnt_inc, pos_inc;
    logic [15:0] len_reg, len_next, len_acc, gapms_reg, gapms_next, frames_reg, frames_next;
    logic [9:0]  trail_reg, trail_next;
    logic [31:0] pre_reg, pre_next;
    logic        take, gap_due, gap_fire, done, close, st_need, start_hit, tail_hit;
    logic        len_fld, len_done, pat_done, fifo_rdy, fin_valid;
    sdp_word_s   fin_word;

    always_comb begin
        c_next      = c_reg;
        st1_next    = st1_reg;
        st2_next    = st2_reg;
        en1_next    = en1_reg;
        en2_next    = en2_reg;
        pextra_next = pextra_reg;
        loff_next   = loff_reg;
        lsize_next  = lsize_reg;
        lextra_next = lextra_reg;
        gap_next    = gap_reg;
        fixed_next  = fixed_reg;
        mtu_next    = mtu_reg;
        pready_o    = ce_i && ack_reg;
        wr_en       = psel_i && penable_i && pwrite_i && pready_o;
        hit         = paddr_i[1:0] == 2'h0 && paddr_i <= `SDP_A_FRAMES;
        pslverr_o   = psel_i && penable_i && pready_o && !hit;
        ack_next    = ce_i ? psel_i && !(penable_i && pready_o) : ack_reg; // held while frozen
        prdata_next = prdata_reg;
        // fields of 2 bits already cap lead and tail patterns at three bytes
        if (wr_en) begin
            case (paddr_i)
                `SDP_A_CTRL:   c_next = pwdata_i[`SDP_F_CTRL];
                `SDP_A_START1: st1_next = pwdata_i;
                `SDP_A_START2: st2_next = pwdata_i;
                `SDP_A_END1:   en1_next = pwdata_i;
                `SDP_A_END2:   en2_next = pwdata_i;
                `SDP_A_TRAIL:  pextra_next = pwdata_i[`SDP_F_CNT];
                `SDP_A_LENCFG: begin
                    loff_next  = pwdata_i[`SDP_F_LOFF];
                    lsize_next = pwdata_i[`SDP_F_LSIZE] > `SDP_LSIZE_MAX ? `SDP_LSIZE_MAX
                                                                         : pwdata_i[`SDP_F_LSIZE];
                end
                `SDP_A_LENADJ: lextra_next = pwdata_i[`SDP_F_CNT];
                `SDP_A_GAP:    gap_next = pwdata_i[`SDP_F_GAP];
                `SDP_A_FIXED:  fixed_next = pwdata_i[`SDP_F_LEN];
                `SDP_A_MTU:    mtu_next = pwdata_i[`SDP_F_LEN] > `SDP_MTU_MAX ? `SDP_MTU_MAX
                                                                            : pwdata_i[`SDP_F_LEN];
                default:       c_next = c_reg;
            endcase
        end
        if (ce_i && ack_next && !pwrite_i) begin
            case (paddr_i)
                `SDP_A_CTRL:   prdata_next = {27'h0, c_reg};
                `SDP_A_START1: prdata_next = st1_reg;
                `SDP_A_START2: prdata_next = st2_reg;
                `SDP_A_END1:   prdata_next = en1_reg;
                `SDP_A_END2:   prdata_next = en2_reg;
                `SDP_A_TRAIL:  prdata_next = {22'h0, pextra_reg};
                `SDP_A_LENCFG: prdata_next = {14'h0, lsize_reg, 6'h0, loff_reg};
                `SDP_A_LENADJ: prdata_next = {22'h0, lextra_reg};
                `SDP_A_GAP:    prdata_next = {16'h0, gap_reg};
                `SDP_A_FIXED:  prdata_next = {21'h0, fixed_reg};
                `SDP_A_MTU:    prdata_next = {21'h0, mtu_reg};
                `SDP_A_STATUS: prdata_next = {15'h0, !fifo_rdy, 1'h0, state_reg, 1'h0, cnt_reg};
                `SDP_A_FRAMES: prdata_next = {16'h0, frames_reg};
                default:       prdata_next = 32'h0;
            endcase
        end
        prdata_o  = prdata_reg;
        fixed_eff = fixed_reg > mtu_reg ? mtu_reg : fixed_reg;
        gap_eff   = gap_reg < `SDP_GAP_MIN ? `SDP_GAP_MIN : gap_reg;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            c_reg      <= '0;
            st1_reg    <= '0;
            st2_reg    <= '0;
            en1_reg    <= '0;
            en2_reg    <= '0;
            pextra_reg <= '0;
            loff_reg   <= '0;
            lsize_reg  <= `SDP_LSIZE_RST;
            lextra_reg <= '0;
            gap_reg    <= `SDP_GAP_MIN;
            fixed_reg  <= `SDP_FIXED_RST;
            mtu_reg    <= `SDP_MTU_RST;
            prdata_reg <= '0;
            ack_reg    <= 1'b0;
        end else begin
            c_reg      <= c_next;
            st1_reg    <= st1_next;
            st2_reg    <= st2_next;
            en1_reg    <= en1_next;
            en2_reg    <= en2_next;
            pextra_reg <= pextra_next;
            loff_reg   <= loff_next;
            lsize_reg  <= lsize_next;
            lextra_reg <= lextra_next;
            gap_reg    <= gap_next;
            fixed_reg  <= fixed_next;
            mtu_reg    <= mtu_next;
            prdata_reg <= prdata_next;
            ack_reg    <= ack_next;
        end
    end

    // ****************************************
    // framer
    // ****************************************
    function automatic logic pmatch(input logic [23:0] h, input sdp_pat_s p);
        logic [23:0] m;
        m = p.size == 2'h1 ? 24'h0000ff : p.size == 2'h2 ? 24'h00ffff : 24'hffffff;
        return p.size != 2'h0 && ((h ^ p.seq) & m) == 24'h0;
    endfunction : pmatch

    always_comb begin
        st_need   = (c_reg.pat && (st1_reg.size != 2'h0 || st2_reg.size != 2'h0))
                 || (c_reg.len && st1_reg.size != 2'h0);
        take      = ce_i && rx_valid_i && fifo_rdy;
        hist_in   = {hist_reg[15:0], rx_data_i};
        cnt_inc   = cnt_reg + 11'h001;
        pos_inc   = pos_reg + 11'h001;
        start_hit = pmatch(hist_in, st1_reg) || (c_reg.pat && pmatch(hist_in, st2_reg));
        tail_hit  = c_reg.pat && (pmatch(hist_in, en1_reg) || pmatch(hist_in, en2_reg));
        len_fld   = c_reg.len && state_reg == SDP_BODY && pos_reg >= {1'b0, loff_reg}
                 && pos_reg < {1'b0, loff_reg} + {9'h0, lsize_reg};
        len_acc   = len_reg;
        if (len_fld) begin
            if (c_reg.netord) begin
                len_acc = {len_reg[7:0], rx_data_i};
            end else if (pos_reg == {1'b0, loff_reg}) begin
                len_acc = {8'h00, rx_data_i};
            end else begin
                len_acc = {rx_data_i, len_reg[7:0]};
            end
        end
        // a short field before the length arrives cannot close the datagram early
        len_done  = c_reg.len && state_reg == SDP_BODY
                 && pos_inc >= {1'b0, loff_reg} + {9'h0, lsize_reg}
                 && {5'h0, pos_inc} == len_acc + {6'h0, lextra_reg};
        pat_done  = (state_reg == SDP_BODY && tail_hit && pextra_reg == 10'h0)
                 || (state_reg == SDP_TRAIL && trail_reg == 10'h001);
        close     = pat_done || len_done || (c_reg.fix && cnt_inc >= fixed_eff)
                 || cnt_inc >= mtu_reg;
        gap_due   = ce_i && c_reg.gap && !rx_valid_i && cnt_reg != 11'h0
                 && gapms_reg >= gap_eff;
        gap_fire  = gap_due && fifo_rdy;
        done      = (take && close) || gap_fire;
        fin_valid = ce_i && (rx_valid_i || gap_due);
        // the gap close carries no byte: it only ends the datagram
        fin_word  = rx_valid_i ? sdp_word_s'{empty: 1'b0, last: close, data: rx_data_i}
                               : sdp_word_s'{empty: 1'b1, last: 1'b1, data: 8'h00};
        rx_ready_o  = ce_i && fifo_rdy;
        state_next  = state_reg;
        hist_next   = hist_reg;
        cnt_next    = cnt_reg;
        pos_next    = pos_reg;
        len_next    = len_reg;
        trail_next  = trail_reg;
        gapms_next  = gapms_reg;
        pre_next    = pre_reg;
        frames_next = frames_reg;
        if (take) begin
            hist_next  = hist_in;
            cnt_next   = cnt_inc;
            pos_next   = pos_inc;
            len_next   = len_acc;
            gapms_next = 16'h0;
            pre_next   = 32'h0;
            case (state_reg)
                SDP_HUNT: begin
                    if (start_hit) begin
                        state_next = SDP_BODY;
                        pos_next   = {9'h0, pmatch(hist_in, st1_reg) ? st1_reg.size : st2_reg.size};
                    end
                end
                SDP_BODY: begin
                    if (tail_hit && pextra_reg != 10'h0) begin
                        state_next = SDP_TRAIL;
                        trail_next = pextra_reg;
                    end
                end
                SDP_TRAIL: trail_next = trail_reg - 10'h001;
                default:   state_next = SDP_BODY;
            endcase
        end else if (ce_i && cnt_reg != 11'h0) begin
            // a ms tick restarts with each byte, so the gap is accurate to one clock
            if (pre_reg >= 32'(MS_CYC - 1)) begin
                pre_next   = 32'h0;
                gapms_next = gapms_reg == 16'hffff ? gapms_reg : gapms_reg + 16'h0001;
            end else begin
                pre_next = pre_reg + 32'h1;
            end
        end
        if (done) begin
            state_next  = st_need ? SDP_HUNT : SDP_BODY;
            hist_next   = 24'h0;
            cnt_next    = 11'h0;
            pos_next    = 11'h0;
            len_next    = 16'h0;
            trail_next  = 10'h0;
            gapms_next  = 16'h0;
            pre_next    = 32'h0;
            frames_next = frames_reg + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg  <= SDP_BODY;
            hist_reg   <= '0;
            cnt_reg    <= '0;
            pos_reg    <= '0;
            len_reg    <= '0;
            trail_reg  <= '0;
            gapms_reg  <= '0;
            pre_reg    <= '0;
            frames_reg <= '0;
        end else begin
            state_reg  <= state_next;
            hist_reg   <= hist_next;
            cnt_reg    <= cnt_next;
            pos_reg    <= pos_next;
            len_reg    <= len_next;
            trail_reg  <= trail_next;
            gapms_reg  <= gapms_next;
            pre_reg    <= pre_next;
            frames_reg <= frames_next;
        end
    end

    // back-pressure from the network stalls serial reception
    sdp_fifo #(.W($bits(sdp_word_s)), .DEPTH(DEPTH)) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rstn_i      (rstn_i),
        .ce_i        (ce_i),
        .in_valid_i  (fin_valid),
        .in_ready_o  (fifo_rdy),
        .in_data_i   (fin_word),
        .out_valid_o (net_valid_o),
        .out_ready_i (net_ready_i),
        .out_data_o  (net_word_o)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_tail_arm;
        take && state_reg == SDP_BODY && tail_hit && pextra_reg != 10'h0 && !close;
    endsequence
    property p_trail_wait;
        s_tail_arm |=> state_reg == SDP_TRAIL && trail_reg == $past(pextra_reg);
    endproperty
    a_trail_wait: assert property (p_trail_wait) else $error("trailer count not loaded");
    property p_tail_close;
        take && state_reg == SDP_BODY && tail_hit && pextra_reg == 10'h0 |-> fin_word.last ##1 cnt_reg == 11'h0;
    endproperty
    a_tail_close: assert property (p_tail_close) else $error("tail did not close");
    property p_no_lead;
        done && !st_need |=> state_reg == SDP_BODY;
    endproperty
    a_no_lead: assert property (p_no_lead) else $error("hunting without lead");
    property p_hunt_hold;
        take && state_reg == SDP_HUNT && !start_hit && !close |=> state_reg == SDP_HUNT;
    endproperty
    a_hunt_hold: assert property (p_hunt_hold) else $error("armed without lead");
    property p_len_close;
        take && len_done |-> fin_word.last && {5'h0, pos_inc} == len_acc + {6'h0, lextra_reg} ##1 cnt_reg == 11'h0;
    endproperty
    a_len_close: assert property (p_len_close) else $error("length close wrong");
    property p_netord;
        take && len_fld && c_reg.netord |=> len_reg[7:0] == $past(rx_data_i);
    endproperty
    a_netord: assert property (p_netord) else $error("length byte order wrong");
    property p_fixed;
        take && c_reg.fix && cnt_inc == fixed_eff |-> fin_word.last && fixed_eff <= mtu_reg;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed count missed");
    property p_mtu;
        take && cnt_inc == mtu_reg |-> fin_word.last ##1 cnt_reg == 11'h0;
    endproperty
    a_mtu: assert property (p_mtu) else $error("transfer size not enforced");
    property p_gap;
        fin_valid && fin_word.empty |-> c_reg.gap && gapms_reg >= `SDP_GAP_MIN;
    endproperty
    a_gap: assert property (p_gap) else $error("gap close too early");
    property p_clear;
        done |=> cnt_reg == 11'h0 && hist_reg == 24'h0 && gapms_reg == 16'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("state not cleared");
endmodule : sdp_packetizer
`default_nettype wire

// file: sdp_net_sink.sv
// Purpose: network side model that takes words from the packetizer
// Assumes: plain valid/ready, word taken when both high at an edge
// Notes:   stalls one cycle in four, hold_i stalls it fully
`timescale 1ns/10ps
`default_nettype none
module sdp_net_sink (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    // control
    input  wire logic hold_i,
    // stream
    output logic      net_ready_o
);
    logic [2:0] cnt_reg;
    // periodic stalls keep words standing across several edges
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg     <= 3'h0;
            net_ready_o <= 1'b0;
        end else begin
            cnt_reg     <= cnt_reg + 3'h1;
            net_ready_o <= !hold_i && (cnt_reg[1:0] != 2'h3);
        end
    end
endmodule : sdp_net_sink
`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench of the packetizer
// Assumes: ms tick shortened to 10 cycles
// Notes:   expected words queue up as bytes are taken
`timescale 1ns/10ps
`default_nettype none
`include "sdp_regs.svh"
module tb_top;
    import sdp_pkg::*;
    logic        ref_clk_i, rstn_i, psel, penable, pwrite, rx_valid, net_ready, hold, pready, pslverr, rx_ready;
    logic        net_valid, er;
    logic [7:0]  paddr, rx_data, seed;
    logic [31:0] pwdata, prdata, rd;
    sdp_word_s   net_word;
    logic [9:0]  exp_q[$];
    int          num_errors, samples_checked;
    localparam logic [8:0] PAT[7] = '{9'h041, 9'h00d, 9'h00a, 9'h155, 9'h00a, 9'h00d, 9'h166};
    localparam logic [7:0] LEN[7] = '{8'h02, 8'h00, 8'h05, 8'ha1, 8'hb2, 8'hc3, 8'hd4};
    sdp_packetizer #(.MS_CYC(10), .DEPTH(32)) dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_valid_i(rx_valid),
        .rx_data_i(rx_data), .rx_ready_o(rx_ready), .net_valid_o(net_valid), .net_word_o(net_word),
        .net_ready_i(net_ready));
    sdp_net_sink sink_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .hold_i(hold), .net_ready_o(net_ready));
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = !ref_clk_i;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    // apb master: request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // byte held until the rising edge that takes it
    task automatic tx(input logic [7:0] b, input logic lst);
        @(posedge ref_clk_i);
        rx_valid <= 1'b1;
        rx_data  <= b;
        do @(posedge ref_clk_i); while (rx_ready !== 1'b1);
        exp_q.push_back({1'b0, lst, b});
        rx_valid <= 1'b0;
    endtask : tx
    task automatic frame(input int n);
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            tx(seed, i == n - 1);
        end
    endtask : frame
    task automatic drain(input string nm);
        repeat (400) if (exp_q.size() != 0) @(posedge ref_clk_i);
        cmp(exp_q.size(), 0);
        $display("test %s done", nm);
    endtask : drain
    // empty words carry no byte, so their data field is not compared
    always @(posedge ref_clk_i) begin
        if (net_valid === 1'b1 && net_ready === 1'b1)
            cmp({22'h0, net_word[9:8], net_word[9] ? 8'h00 : net_word[7:0]}, exp_q.size() ? exp_q.pop_front() : 10'h3ff);
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        num_errors++;
        give_verdict();
    end
    initial begin
        {rstn_i, psel, penable, pwrite, rx_valid, hold, paddr, rx_data, pwdata} = '0;
        seed = 8'h60;
        repeat (12) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        apb(1'b0, `SDP_A_GAP, 32'h0);
        cmp(rd, 32'h3);
        apb(1'b0, `SDP_A_CTRL, 32'h0);
        cmp(rd, 32'h0);
        apb(1'b1, 8'h34, 32'h1);
        cmp({31'h0, er}, 32'h1);
        apb(1'b0, `SDP_A_MTU, 32'h0);
        cmp(rd, 32'h230);
        apb(1'b1, `SDP_A_MTU, 32'h7ff);
        apb(1'b0, `SDP_A_MTU, 32'h0);
        cmp(rd, 32'h400);
        drain("regs");
        apb(1'b1, `SDP_A_END1, 32'h0200_0d0a);
        apb(1'b1, `SDP_A_END2, 32'h0200_0a0d);
        apb(1'b1, `SDP_A_TRAIL, 32'h1);
        apb(1'b1, `SDP_A_CTRL, 32'h1);
        foreach (PAT[i]) tx(PAT[i][7:0], PAT[i][8]);
        drain("pattern");
        apb(1'b1, `SDP_A_START1, 32'h0100_0002);
        apb(1'b1, `SDP_A_LENCFG, 32'h0002_0001);
        apb(1'b1, `SDP_A_LENADJ, 32'h2);
        for (int o = 1; o >= 0; o--) begin
            apb(1'b1, `SDP_A_CTRL, {27'h0, o[0], 4'h2});
            foreach (LEN[i]) tx(LEN[o ? i : (i == 1 ? 2 : i == 2 ? 1 : i)], i == 6);
        end
        drain("length");
        apb(1'b1, `SDP_A_FIXED, 32'h4);
        apb(1'b1, `SDP_A_CTRL, 32'h8);
        repeat (2) frame(4);
        drain("fixed");
        apb(1'b1, `SDP_A_GAP, 32'h1);
        apb(1'b1, `SDP_A_CTRL, 32'h4);
        repeat (3) tx(lfsr(seed), 1'b0);
        exp_q.push_back(10'h300);
        drain("gap");
        apb(1'b1, `SDP_A_CTRL, 32'h0);
        apb(1'b1, `SDP_A_MTU, 32'h8);
        hold <= 1'b1;
        repeat (4) frame(8);
        @(negedge ref_clk_i);
        cmp({31'h0, rx_ready}, 32'h0);
        hold <= 1'b0;
        frame(8);
        drain("mtu");
        // two pattern, two length, two fixed, one gap and five size closes
        apb(1'b0, `SDP_A_FRAMES, 32'h0);
        cmp(rd, 32'hc);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
